// [inc/iras_pkg.sv]
// Constants and state encoding shared by the serial register port.
package iras_pkg;

  // ----------------------------------------------------------------
  // register pointer
  // ----------------------------------------------------------------
  localparam int         ADDR_W   = 14;    // byte address width
  localparam int         ADHI_W   = 6;     // address bits in high byte
  localparam int         DIR_MSB  = 7;     // stepping field in high byte
  localparam int         DIR_LSB  = 6;
  localparam logic [1:0] DIR_INC  = 2'h0;  // step up
  localparam logic [1:0] DIR_RSV  = 2'h1;  // reserved, stepped as up
  localparam logic [1:0] DIR_DEC  = 2'h2;  // step down
  localparam logic [1:0] DIR_FIX  = 2'h3;  // pointer held

  // ----------------------------------------------------------------
  // bus framing
  // ----------------------------------------------------------------
  localparam int         SADDR_W  = 7;     // slave address width
  localparam logic [7:0] GC_ADDR  = 8'h00; // general call, write
  localparam logic [3:0] BIT_LAST = 4'h7;  // rises seen before 8th bit
  localparam logic [3:0] BIT_ACK  = 4'h8;  // rises seen before ack bit
  localparam logic [3:0] BIT_END  = 4'h9;  // ack bit clocked
  localparam logic [1:0] NB_MULTI = 2'h2;  // byte count meaning multi
  localparam logic [1:0] STRAP_DLY = 2'h3; // strap settle after reset

  // byte engine states
  typedef enum logic [2:0] {
    S_IDLE,  // ignoring the bus until a start
    S_CTRL,  // receiving the control byte
    S_GC,    // second byte of a general call
    S_AHI,   // register address, high byte
    S_ALO,   // register address, low byte
    S_WDAT,  // write data bytes
    S_RDAT,  // sending read data
    S_DONE   // read ended by master, bus released
  } iras_state_t;

endpackage

// [rtl/iras_slave.sv]
// Two-wire slave command engine giving a bus master byte access to CSRs.
`timescale 1ns/100ps

module iras_slave #(
  parameter int ADDR_W = iras_pkg::ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              scl_clk,      // link clock pin
  input  wire logic              sda_in,
  output wire logic              sda_out,
  output wire logic              sda_oe_n,
  output wire logic              scl_out,
  output wire logic              scl_oe_n,
  input  wire logic [6:0]        strap_addr,
  input  wire logic              init_done,
  input  wire logic              low_power,
  input  wire logic              clk_locked,
  input  wire logic [7:0]        reg_rdata,
  output wire logic [ADDR_W-1:0] reg_addr,
  output wire logic [7:0]        reg_wdata,
  output wire logic              reg_wr,
  output wire logic              reg_rd,
  output wire logic              wake_req,
  output wire logic              sleep_return
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    iras_pkg::iras_state_t st;
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_p;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_p;
    logic              lk_s1;
    logic              lk_s2;
    logic [6:0]        strap1;
    logic [6:0]        strap2;
    logic [1:0]        strap_cnt;
    logic [6:0]        saddr;
    logic              armed;
    logic              tx;
    logic              is_ack;
    logic [7:0]        shift;
    logic [3:0]        bitcnt;
    logic [7:0]        ahi;
    logic [ADDR_W-1:0] ptr;
    logic [1:0]        dir;
    logic [ADDR_W-1:0] cur;
    logic [1:0]        nbytes;
    logic              sda_oe_n;
    logic              scl_oe_n;
    logic              wake_req;
    logic              sleep_ret;
    logic              reg_wr;
    logic              reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        reg_wdata;
  } iras_regs_t;

  iras_regs_t r;
  iras_regs_t n;
  logic       bit_q;

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  // data bit caught on the master's own rising edge; it stays put a
  // whole link period, so the core reads it only after it has seen
  // the synchronised rising edge of the same clock
  always_ff @(posedge scl_clk) begin
    bit_q <= sda_in;
  end

  // ----------------------------------------------------------------
  // pointer stepping
  // ----------------------------------------------------------------
  // reserved code steps up so a stray write cannot stick the pointer
  function automatic logic [ADDR_W-1:0] step_ptr(
    input logic [ADDR_W-1:0] p,
    input logic [1:0]        d
  );
    logic [ADDR_W-1:0] q;
    q = p;
    case (d)
      iras_pkg::DIR_DEC: q = p - 1'b1;
      iras_pkg::DIR_FIX: q = p;
      default:           q = p + 1'b1;
    endcase
    return q;
  endfunction

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic              rise_ev;
  logic              fall_ev;
  logic              start_ev;
  logic              stop_ev;
  logic              multi;
  logic [7:0]        rx_byte;
  logic [ADDR_W-1:0] cur_step;

  // only second stages and their delayed copies are looked at
  assign rise_ev  = r.scl_s2 & ~r.scl_p;
  assign fall_ev  = ~r.scl_s2 & r.scl_p;
  assign start_ev = r.scl_s2 & r.scl_p & r.sda_p & ~r.sda_s2;
  assign stop_ev  = r.scl_s2 & r.scl_p & ~r.sda_p & r.sda_s2;
  assign multi    = r.nbytes >= iras_pkg::NB_MULTI;
  assign rx_byte  = {r.shift[6:0], bit_q};
  assign cur_step = step_ptr(r.cur, r.dir);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n           = r;
    n.reg_wr    = 1'b0;
    n.reg_rd    = 1'b0;
    n.sleep_ret = 1'b0;
    // two-stage synchronisers for pins and the lock flag
    n.scl_s1 = scl_clk;
    n.scl_s2 = r.scl_s1;
    n.scl_p  = r.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_p  = r.sda_s2;
    n.lk_s1  = clk_locked;
    n.lk_s2  = r.lk_s1;
    n.strap1 = strap_addr;
    n.strap2 = r.strap1;
    // strap is followed for a few cycles after reset, then frozen
    if (r.strap_cnt != iras_pkg::STRAP_DLY) begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      n.saddr     = r.strap2;
    end
    // clock stretch ends once the clocks report lock
    if (!r.scl_oe_n && r.lk_s2) begin
      n.scl_oe_n = 1'b1;
    end

    if (start_ev || stop_ev) begin
      // a frame edge ends whatever was under way; a multi-byte
      // transfer leaves the pointer where stepping took it
      if ((r.st == iras_pkg::S_WDAT || r.st == iras_pkg::S_RDAT ||
           r.st == iras_pkg::S_DONE) && multi) begin
        n.ptr = r.cur;
      end
      n.sda_oe_n = 1'b1;
      n.tx       = 1'b0;
      n.is_ack   = 1'b0;
      n.bitcnt   = 4'h0;
      n.st       = iras_pkg::S_IDLE;
      if (stop_ev) begin
        n.wake_req = 1'b0;
      end
      // bus stays deaf until the first start once init is done
      if (start_ev && (r.armed || init_done)) begin
        n.armed = 1'b1;
        n.st    = iras_pkg::S_CTRL;
        // wake on start, before any address bit is known
        if (low_power && !r.wake_req) begin
          n.wake_req = 1'b1;
          n.scl_oe_n = r.lk_s2;
        end
      end
    end else if (rise_ev && r.st != iras_pkg::S_IDLE &&
                 r.st != iras_pkg::S_DONE) begin
      n.bitcnt = r.bitcnt + 4'h1;
      if (!r.tx && r.bitcnt < iras_pkg::BIT_ACK) begin
        n.shift = rx_byte;
      end
      if (!r.tx && r.bitcnt == iras_pkg::BIT_LAST) begin
        // whole byte in: decide the ack and act on the byte
        n.is_ack = 1'b1;
        case (r.st)
          iras_pkg::S_CTRL: begin
            if (rx_byte[7:1] == r.saddr) begin
              if (rx_byte[0]) begin
                n.st       = iras_pkg::S_RDAT;
                n.cur      = r.ptr;
                n.nbytes   = 2'h0;
                n.reg_rd   = 1'b1;
                n.reg_addr = r.ptr;
              end else begin
                n.st = iras_pkg::S_AHI;
              end
            end else if (rx_byte == iras_pkg::GC_ADDR) begin
              n.st = iras_pkg::S_GC;
            end else begin
              // not ours: no ack, and a wake we caused is undone
              n.is_ack = 1'b0;
              n.st     = iras_pkg::S_IDLE;
              if (r.wake_req) begin
                n.wake_req  = 1'b0;
                n.sleep_ret = 1'b1;
              end
            end
          end
          iras_pkg::S_GC: begin
            if (rx_byte[0]) begin
              n.st = iras_pkg::S_AHI;
            end else begin
              n.is_ack = 1'b0;
              n.st     = iras_pkg::S_IDLE;
            end
          end
          iras_pkg::S_AHI: begin
            n.ahi = rx_byte;
            n.st  = iras_pkg::S_ALO;
          end
          iras_pkg::S_ALO: begin
            // unused high address bits are taken as the master sent
            // them; stepping field is stored with every address
            n.ptr    = {r.ahi[iras_pkg::ADHI_W-1:0], rx_byte};
            n.cur    = {r.ahi[iras_pkg::ADHI_W-1:0], rx_byte};
            n.dir    = r.ahi[iras_pkg::DIR_MSB:iras_pkg::DIR_LSB];
            n.nbytes = 2'h0;
            n.st     = iras_pkg::S_WDAT;
          end
          iras_pkg::S_WDAT: begin
            n.reg_wr    = 1'b1;
            n.reg_addr  = r.cur;
            n.reg_wdata = rx_byte;
            n.cur       = cur_step;
            if (!multi) begin
              n.nbytes = r.nbytes + 2'h1;
            end
          end
          default: begin
            n.is_ack = 1'b0;
            n.st     = iras_pkg::S_IDLE;
          end
        endcase
      end
      if (r.tx && r.bitcnt == iras_pkg::BIT_ACK) begin
        // ack bit from the master ends each read byte
        n.cur = cur_step;
        if (!multi) begin
          n.nbytes = r.nbytes + 2'h1;
        end
        if (!bit_q) begin
          n.reg_rd   = 1'b1;
          n.reg_addr = cur_step;
        end else begin
          // master declined: no further byte is driven
          n.st = iras_pkg::S_DONE;
          n.tx = 1'b0;
          if (r.nbytes != 2'h0) begin
            n.ptr = cur_step;
          end
        end
      end
    end else if (fall_ev && r.st != iras_pkg::S_IDLE) begin
      if (r.bitcnt == iras_pkg::BIT_ACK) begin
        // ack slot: drive low when accepting, let go when sending
        n.sda_oe_n = r.tx | ~r.is_ack;
      end else if (r.bitcnt == iras_pkg::BIT_END) begin
        n.bitcnt   = 4'h0;
        n.is_ack   = 1'b0;
        n.sda_oe_n = 1'b1;
        if (r.st == iras_pkg::S_RDAT) begin
          // data must be back from the register file by now
          n.tx       = 1'b1;
          n.shift    = reg_rdata;
          n.sda_oe_n = reg_rdata[7];
        end
      end else if (r.tx && r.bitcnt != 4'h0) begin
        n.shift    = {r.shift[6:0], 1'b0};
        n.sda_oe_n = r.shift[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // released lines at reset; the engine ignores the bus until armed
  always_ff @(posedge clk) begin
    if (reset) begin
      r          <= '0;
      r.st       <= iras_pkg::S_IDLE;
      r.sda_oe_n <= 1'b1;
      r.scl_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the open-drain pins only ever pull low
  assign sda_out      = r.reg_wdata[0] & 1'b0;
  assign scl_out      = r.reg_wdata[0] & 1'b0;
  assign sda_oe_n     = r.sda_oe_n;
  assign scl_oe_n     = r.scl_oe_n;
  assign reg_addr     = r.reg_addr;
  assign reg_wdata    = r.reg_wdata;
  assign reg_wr       = r.reg_wr;
  assign reg_rd       = r.reg_rd;
  assign wake_req     = r.wake_req;
  assign sleep_return = r.sleep_ret;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // nothing is driven before the engine is armed
  init_quiet_a: assert property (
    @(posedge clk) disable iff (reset)
    !r.armed |-> r.sda_oe_n && !reg_wr && !reg_rd)
    else $error("bus driven before init");
  // frame edges release the data line on the next cycle
  edge_release_a: assert property (
    @(posedge clk) disable iff (reset)
    (start_ev || stop_ev) |=> r.sda_oe_n && !r.tx)
    else $error("data line held across start or stop");
  // foreign address: no ack slot driven for the rest of the byte
  addr_miss_a: assert property (
    @(posedge clk) disable iff (reset)
    (rise_ev && !r.tx && r.st == iras_pkg::S_CTRL &&
     r.bitcnt == iras_pkg::BIT_LAST && rx_byte[7:1] != r.saddr &&
     rx_byte != iras_pkg::GC_ADDR)
    |=> r.st == iras_pkg::S_IDLE && !r.is_ack)
    else $error("foreign address not ignored");
  // general call with lsb zero is refused
  gc_reject_a: assert property (
    @(posedge clk) disable iff (reset)
    (rise_ev && r.st == iras_pkg::S_GC &&
     r.bitcnt == iras_pkg::BIT_LAST && !bit_q)
    |=> r.st == iras_pkg::S_IDLE ##1 r.sda_oe_n [*3])
    else $error("general call lsb zero accepted");
  // stored stepping field follows the high address byte
  dir_store_a: assert property (
    @(posedge clk) disable iff (reset)
    (rise_ev && r.st == iras_pkg::S_ALO &&
     r.bitcnt == iras_pkg::BIT_LAST)
    |=> r.dir == r.ahi[iras_pkg::DIR_MSB:iras_pkg::DIR_LSB]
        && r.st == iras_pkg::S_WDAT)
    else $error("stepping field not stored");
  // a write pulse carries the pointer, which then steps
  wr_step_a: assert property (
    @(posedge clk) disable iff (reset)
    reg_wr |-> reg_addr == $past(r.cur) &&
               r.cur == step_ptr(reg_addr, r.dir))
    else $error("write address or step wrong");
  // incrementing past the top lands on zero
  ptr_wrap_a: assert property (
    @(posedge clk) disable iff (reset)
    (reg_wr && r.dir == iras_pkg::DIR_INC && &reg_addr)
    |-> r.cur == '0)
    else $error("pointer did not wrap");
  // a lone byte transfer ending leaves the pointer alone
  single_keep_a: assert property (
    @(posedge clk) disable iff (reset)
    ((start_ev || stop_ev) && r.nbytes == 2'h1 &&
     r.st != iras_pkg::S_ALO) |=> $stable(r.ptr))
    else $error("single transfer moved pointer");
  // stretch ends within three cycles of lock
  stretch_end_a: assert property (
    @(posedge clk) disable iff (reset)
    (!scl_oe_n && clk_locked) [*4] |-> ##[0:0] 1'b0)
    else $error("clock held after lock");
  // going back to sleep happens only from a wake we caused
  sleep_back_a: assert property (
    @(posedge clk) disable iff (reset)
    sleep_return |-> $past(r.wake_req) && !r.wake_req)
    else $error("sleep return without wake");
  // after a declined byte the line stays released
  nack_quiet_a: assert property (
    @(posedge clk) disable iff (reset)
    (r.st == iras_pkg::S_DONE) |-> r.sda_oe_n && !reg_rd)
    else $error("data driven after master nack");

endmodule // iras_slave

// [testbench/iras_host_model.sv]
// Serial bus master model that drives the clock and data lines of the port.
`timescale 1ns/100ps
module iras_host_model #(
  parameter int HALF = 40  // half link period in ns
) (
  output logic      scl_m,  // 1 = clock released
  output logic      sda_m,  // 1 = data released
  input  wire logic scl,
  input  wire logic sda
);
  // the link clock stands high outside frames
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  // ------------------------------------------------------------------
  // bit and condition tasks
  // ------------------------------------------------------------------
  // slow bits keep the clock low longer, because the answering side
  // only moves the data line a few system cycles after a clock fall
  task automatic bit_cyc(input logic b, input bit slow, output logic r);
    #(HALF / 4);
    sda_m = b;
    #(slow ? 4 * HALF : HALF - HALF / 4);
    scl_m = 1'b1;
    for (int i = 0; i < 800 && scl !== 1'b1; i++) #10; // tolerate stretch
    #HALF;
    r = sda;
    scl_m = 1'b0;
  endtask

  // also serves as a repeated start
  task automatic start();
    sda_m = 1'b1;
    #HALF;
    scl_m = 1'b1;
    #(2 * HALF);
    sda_m = 1'b0;
    #(2 * HALF);
    scl_m = 1'b0;
  endtask

  task automatic stop();
    #(HALF / 4);
    sda_m = 1'b0;
    #HALF;
    scl_m = 1'b1;
    #(2 * HALF);
    sda_m = 1'b1;
    #(2 * HALF);
  endtask

  // eight bits msb first, then the slave's acknowledge slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    // first bit is slow: the slave lets go of an earlier ack late
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], i == 7, r);
    bit_cyc(1'b1, 1'b1, r);
    ack = ~r;
  endtask

  // a nack on the last byte tells the slave to send nothing more
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, 1'b1, d[i]);
    // slow, so a nack is not masked by the slave's last data bit
    bit_cyc(~ack, 1'b1, r);
  endtask
endmodule // iras_host_model

// [testbench/test_i2c_register_access_slave.sv]
// Self-checking bench for the serial register access slave.
`timescale 1ns/100ps
module test_i2c_register_access_slave;
  logic        clk        = 1'b0;
  logic        reset      = 1'b1;
  logic        init_done  = 1'b0;
  logic        low_power  = 1'b0;
  logic        clk_locked = 1'b1;
  logic [6:0]  strap_addr = 7'h2C;
  logic [7:0]  reg_rdata  = 8'h00;
  logic [31:0] seed       = 32'h17;
  logic        sl_seen    = 1'b0;
  logic        ack;
  logic [13:0] ptr;
  logic [1:0]  pdir;
  logic [1:0]  dirs [4]   = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic [13:0] wa_q [$];
  logic [13:0] ra_q [$];
  logic [7:0]  wd_q [$];
  int          num_errors = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  wire logic   scl_m, sda_m, scl, sda, sda_out, sda_oe_n, scl_out, scl_oe_n;
  wire logic   reg_wr, reg_rd, wake_req, sleep_return;
  wire logic [13:0] reg_addr;
  wire logic [7:0]  reg_wdata;

  always #12.5 clk = ~clk;
  // open-drain lines with pull-ups
  assign scl = scl_m & (scl_oe_n | scl_out);
  assign sda = sda_m & (sda_oe_n | sda_out);

  iras_slave uut (.clk(clk), .reset(reset), .scl_clk(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .strap_addr(strap_addr), .init_done(init_done),
    .low_power(low_power), .clk_locked(clk_locked), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .wake_req(wake_req), .sleep_return(sleep_return));
  iras_host_model mst (.scl_m(scl_m), .sda_m(sda_m), .scl(scl), .sda(sda));

  // register file stand-in, transfer log and hang guard
  always @(posedge clk) begin
    if (reg_rd) reg_rdata <= rd_val(reg_addr);
    if (reg_rd) ra_q.push_back(reg_addr);
    if (reg_wr) wa_q.push_back(reg_addr);
    if (reg_wr) wd_q.push_back(reg_wdata);
    if (sleep_return) sl_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------------
  // expectations and reporting
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] rd_val(input logic [13:0] a);
    return a[7:0] ^ {2'h0, a[13:8]} ^ 8'h5A;
  endfunction
  // reserved code steps up like the increment code
  function automatic logic [13:0] step(input logic [13:0] a,
                                       input logic [1:0] d);
    return d == 2'h2 ? a - 14'h1 : (d == 2'h3 ? a : a + 14'h1);
  endfunction
  task automatic check(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, num_errors);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // frame tasks
  // ------------------------------------------------------------------
  task automatic ctrl(input logic [7:0] c, input logic exp_ack);
    wa_q.delete();
    wd_q.delete();
    ra_q.delete();
    mst.start();
    mst.wr_byte(c, ack);
    check("control ack", 16'(exp_ack), 16'(ack));
  endtask
  // refused frame: two more bytes must go unacknowledged, nothing written
  task automatic nak_run(input logic [7:0] c, input logic first_ack);
    ctrl(c, first_ack);
    mst.wr_byte(8'h00, ack);
    check("byte ack", 16'h0, 16'(ack));
    mst.wr_byte(8'h13, ack);
    check("byte ack", 16'h0, 16'(ack));
    mst.stop();
    check("write count", 16'h0, 16'(wa_q.size()));
  endtask
  // address bytes then n random data bytes; n of zero only sets the pointer
  task automatic wr_run(input bit gc, input logic [15:0] a, input int n);
    logic [7:0]  d [$];
    logic [13:0] p;
    ctrl(gc ? 8'h00 : {strap_addr, 1'b0}, 1'b1);
    if (gc) mst.wr_byte(8'h01, ack);
    if (gc) check("call ack", 16'h1, 16'(ack));
    mst.wr_byte(a[15:8], ack);
    check("addr ack", 16'h1, 16'(ack));
    mst.wr_byte(a[7:0], ack);
    check("addr ack", 16'h1, 16'(ack));
    for (int i = 0; i < n; i++) begin
      d.push_back(8'(xs()));
      mst.wr_byte(d[i], ack);
      check("data ack", 16'h1, 16'(ack));
    end
    mst.stop();
    repeat (8) @(posedge clk);
    check("write count", 16'(n), 16'(wa_q.size()));
    p = a[13:0];
    for (int i = 0; i < n; i++) begin
      check("write addr", 16'(p), 16'(wa_q[i]));
      check("write data", 16'(d[i]), 16'(wd_q[i]));
      p = step(p, a[15:14]);
    end
    ptr = n > 1 ? p : a[13:0];
    pdir = a[15:14];
  endtask
  // n bytes from the held pointer, master nack on the last
  task automatic rd_run(input int n);
    logic [7:0]  b;
    logic [13:0] p;
    p = ptr;
    ctrl({strap_addr, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.rd_byte(i < n - 1, b);
      check("read data", 16'(rd_val(p)), 16'(b));
      check("fetch addr", 16'(p), 16'(ra_q[i]));
      p = step(p, pdir);
    end
    #200;
    check("data released", 16'h1, 16'(sda_oe_n));
    mst.stop();
    if (n > 1) ptr = p;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    nak_run({strap_addr, 1'b0}, 1'b0);
    @(posedge clk) init_done <= 1'b1;
    repeat (4) @(posedge clk);
    end_test("before init");
    for (int k = 0; k < 4; k++) wr_run(1'b0, {dirs[k], 14'(xs())}, 3);
    end_test("writes");
    rd_run(2);
    rd_run(1);
    rd_run(1);
    wr_run(1'b0, 16'h3FFE, 0);
    rd_run(3);
    rd_run(2);
    wr_run(1'b0, 16'h3FFF, 2);
    end_test("reads");
    nak_run({strap_addr ^ 7'h01, 1'b0}, 1'b0);
    wr_run(1'b1, {2'h0, 14'(xs())}, 2);
    nak_run(8'h00, 1'b1);
    end_test("address and call");
    @(posedge clk) low_power <= 1'b1;
    clk_locked <= 1'b0;
    fork
      nak_run({strap_addr ^ 7'h01, 1'b0}, 1'b0);
      begin
        repeat (14) @(posedge clk);
        check("clock held", 16'h0, 16'(scl_oe_n));
        check("wake", 16'h1, 16'(wake_req));
        clk_locked <= 1'b1;
      end
    join
    check("back to sleep", 16'h1, 16'(sl_seen));
    end_test("wake");
    give_verdict();
  end
endmodule // test_i2c_register_access_slave
